// File: rtl/uls_consts.svh
`ifndef ULS_CONSTS_SVH
`define ULS_CONSTS_SVH

// ===========================================================
// register offsets (byte addresses)
`define ULS_OFF_DATA      8'h00
`define ULS_OFF_LSR       8'h04
`define ULS_OFF_CTRL      8'h08
`define ULS_OFF_ISR       8'h0C
`define ULS_OFF_IMR       8'h10

// ===========================================================
// line status bit positions
`define ULS_LSR_FIFO_ERR  7
`define ULS_LSR_TEMT      6
`define ULS_LSR_THRE      5
`define ULS_LSR_BRK       4
`define ULS_LSR_FRM       3
`define ULS_LSR_PAR       2
`define ULS_LSR_OVR       1
`define ULS_LSR_DR        0

// ===========================================================
// control, interrupt and data field layout
`define ULS_CTRL_FIFO_EN  0
`define ULS_INT_RX        0
`define ULS_INT_LINE      1
`define ULS_INT_THRE      2
`define ULS_INT_W         3
`define ULS_CTRL_RESET    1'b0
`define ULS_MASK_RESET    3'h0
`define ULS_DATA_W        8
`define ULS_ERR_W         3
`define ULS_FIFO_DEPTH    128

`endif

// File: rtl/uls_pkg.sv
package uls_pkg;

  typedef enum {
    ULS_SEL_DATA,
    ULS_SEL_LSR,
    ULS_SEL_CTRL,
    ULS_SEL_ISR,
    ULS_SEL_IMR,
    ULS_SEL_NONE
  } uls_sel_t;

  // error bits stored beside each received character
  typedef struct packed {
    logic brk;
    logic frm;
    logic par;
  } uls_err_t;

endpackage

// File: rtl/uls_mem.sv
`timescale 1ns/1ps

// ===========================================================
// receive storage: registered read with write bypass
module uls_mem #(
  parameter int W     = 11,
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);

  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // bypass so a character written to an empty queue is at the top next cycle
  always_ff @(posedge clk) begin
    if (we && (waddr == raddr)) begin
      rdata <= wdata;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule

// File: rtl/uls_top.sv
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "uls_consts.svh"

module uls_top #(
  parameter int DEPTH = `ULS_FIFO_DEPTH
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        rx_char_valid,
  input  wire logic [7:0]  rx_char_data,
  input  wire logic        rx_parity_err,
  input  wire logic        rx_parity_bit,
  input  wire logic        rx_stop_bit,
  input  wire logic        rx_line,
  input  wire logic        tx_load,
  input  wire logic        tx_shift_busy,
  output logic             tx_wr_valid,
  output logic [7:0]       tx_wr_data,
  output logic             tx_pending
);
  import uls_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam int MW = `ULS_DATA_W + `ULS_ERR_W;
  localparam logic [CW-1:0] CAP_FIFO = CW'(DEPTH);
  localparam logic [CW-1:0] CAP_CHAR = CW'(1);

  typedef struct packed {
    logic                  fifo_en;
    logic [AW-1:0]         wr_ptr;
    logic [AW-1:0]         rd_ptr;
    logic [CW-1:0]         rx_cnt;
    logic [CW-1:0]         err_cnt;
    logic                  ovr;
    logic                  brk_hold;
    logic [CW-1:0]         tx_cnt;
    logic                  tx_wr_valid;
    logic [7:0]            tx_wr_data;
    logic [31:0]           prdata;
    logic                  rd_live;
    logic [`ULS_INT_W-1:0] isr;
    logic [`ULS_INT_W-1:0] imr;
  } uls_state_t;

  uls_state_t s_reg;
  uls_state_t s_next;

  logic [MW-1:0] mem_rdata;
  logic [MW-1:0] mem_wdata;
  logic          push;

  // ===========================================================
  // helpers
  function automatic uls_sel_t decode(input logic [7:0] a);
    unique case (a)
      `ULS_OFF_DATA: decode = ULS_SEL_DATA;
      `ULS_OFF_LSR:  decode = ULS_SEL_LSR;
      `ULS_OFF_CTRL: decode = ULS_SEL_CTRL;
      `ULS_OFF_ISR:  decode = ULS_SEL_ISR;
      `ULS_OFF_IMR:  decode = ULS_SEL_IMR;
      default:       decode = ULS_SEL_NONE;
    endcase
  endfunction

  function automatic logic [CW-1:0] step(input logic [CW-1:0] c, input logic up, input logic dn);
    step = c + CW'(up) - CW'(dn);
  endfunction

  // ===========================================================
  // combinational next state
  uls_sel_t      sel;
  logic          setup;
  logic          wr;
  logic          rd;
  logic [CW-1:0] cap;
  uls_err_t      new_err;
  uls_err_t      top_err;
  logic          rx_ok;
  logic          full;
  logic          pop;
  logic          ovr_set;
  logic          tx_wr;
  logic          tx_take;
  logic          tx_dec;
  logic          thre;
  logic          temt;
  logic [7:0]    line_status;
  logic          flush;
  logic [`ULS_INT_W-1:0] int_set;

  always_comb begin
    s_next   = s_reg;
    sel      = decode(paddr);
    setup    = psel & ~penable;
    wr       = psel & penable & pwrite;
    rd       = psel & penable & ~pwrite;
    cap      = s_reg.fifo_en ? CAP_FIFO : CAP_CHAR;

    // receive side
    new_err.par = rx_parity_err;
    new_err.frm = ~rx_stop_bit;
    new_err.brk = (rx_char_data == 8'h00) & ~rx_stop_bit & ~rx_parity_bit;
    // in FIFO mode, while a break persists only its first character is queued
    rx_ok    = rx_char_valid & ~(s_reg.fifo_en & s_reg.brk_hold & new_err.brk);
    full     = (s_reg.rx_cnt == cap);
    push     = rx_ok & ~full;
    ovr_set  = rx_ok & full;
    pop      = rd & (sel == ULS_SEL_DATA) & s_reg.rd_live;
    mem_wdata = {new_err, rx_char_data};
    top_err  = (s_reg.rx_cnt != '0) ? uls_err_t'(mem_rdata[MW-1:`ULS_DATA_W]) : uls_err_t'('0);

    // transmit side
    tx_wr    = wr & (sel == ULS_SEL_DATA);
    tx_dec   = tx_load & (s_reg.tx_cnt != '0);
    // character mode overwrites the one holding slot, so the count sticks at 1
    tx_take  = tx_wr & (s_reg.tx_cnt < cap);
    thre     = (s_reg.tx_cnt == '0);
    temt     = thre & ~tx_shift_busy;

    line_status = 8'h00;
    line_status[`ULS_LSR_FIFO_ERR] = s_reg.fifo_en & (s_reg.err_cnt != '0);
    line_status[`ULS_LSR_TEMT]     = temt;
    line_status[`ULS_LSR_THRE]     = thre;
    line_status[`ULS_LSR_BRK]      = top_err.brk;
    line_status[`ULS_LSR_FRM]      = top_err.frm;
    line_status[`ULS_LSR_PAR]      = top_err.par;
    line_status[`ULS_LSR_OVR]      = s_reg.ovr;
    line_status[`ULS_LSR_DR]       = (s_reg.rx_cnt != '0);

    // ===========================================================
    // queue bookkeeping
    s_next.rx_cnt  = step(s_reg.rx_cnt, push, pop);
    s_next.err_cnt = step(s_reg.err_cnt, push & (|new_err), pop & (|top_err));
    s_next.wr_ptr  = s_reg.wr_ptr + AW'(push);
    s_next.rd_ptr  = s_reg.rd_ptr + AW'(pop);
    s_next.tx_cnt  = step(s_reg.tx_cnt, tx_take, tx_dec);
    s_next.tx_wr_valid = tx_wr;
    if (tx_wr) begin
      s_next.tx_wr_data = pwdata[7:0];
    end

    // break hold ends once the line returns to mark
    if (~rx_line) begin
      s_next.brk_hold = s_reg.brk_hold | (push & new_err.brk);
    end else begin
      s_next.brk_hold = 1'b0;
    end

    // only the overrun bit that was actually read is cleared; a new one wins
    s_next.ovr = (s_reg.ovr & ~(rd & (sel == ULS_SEL_LSR) & s_reg.prdata[`ULS_LSR_OVR])) | ovr_set;

    // ===========================================================
    // register writes
    flush = 1'b0;
    if (wr && sel == ULS_SEL_CTRL) begin
      s_next.fifo_en = pwdata[`ULS_CTRL_FIFO_EN];
      flush = (pwdata[`ULS_CTRL_FIFO_EN] != s_reg.fifo_en);
    end
    if (wr && sel == ULS_SEL_IMR) begin
      s_next.imr = pwdata[`ULS_INT_W-1:0];
    end
    // switching modes empties both queues, as the old contents mean nothing now
    if (flush) begin
      s_next.wr_ptr  = '0;
      s_next.rd_ptr  = '0;
      s_next.rx_cnt  = '0;
      s_next.err_cnt = '0;
      s_next.tx_cnt  = '0;
    end

    // ===========================================================
    // interrupts: sticky, write one to clear, set wins
    int_set = '0;
    int_set[`ULS_INT_RX]   = push;
    int_set[`ULS_INT_LINE] = (push & (|new_err)) | ovr_set;
    int_set[`ULS_INT_THRE] = (s_next.tx_cnt == '0) & ~thre;
    s_next.isr = s_reg.isr;
    if (wr && sel == ULS_SEL_ISR) begin
      s_next.isr = s_reg.isr & ~pwdata[`ULS_INT_W-1:0];
    end
    s_next.isr = s_next.isr | int_set;

    // ===========================================================
    // read data captured in the setup cycle
    if (setup && !pwrite) begin
      s_next.rd_live = (sel == ULS_SEL_DATA) & (s_reg.rx_cnt != '0);
      unique case (sel)
        ULS_SEL_DATA: s_next.prdata = (s_reg.rx_cnt != '0) ? {24'h000000, mem_rdata[7:0]} : 32'h00000000;
        ULS_SEL_LSR:  s_next.prdata = {24'h000000, line_status};
        ULS_SEL_CTRL: s_next.prdata = {31'h00000000, s_reg.fifo_en};
        ULS_SEL_ISR:  s_next.prdata = {29'h00000000, s_reg.isr};
        ULS_SEL_IMR:  s_next.prdata = {29'h00000000, s_reg.imr};
        ULS_SEL_NONE: s_next.prdata = 32'h00000000;
      endcase
    end
  end

  // ===========================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg         <= '0;
      s_reg.fifo_en <= `ULS_CTRL_RESET;
      s_reg.imr     <= `ULS_MASK_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  uls_mem #(
    .W     (MW),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .clk   (pclk),
    .we    (push),
    .waddr (s_reg.wr_ptr),
    .wdata (mem_wdata),
    .raddr (s_next.rd_ptr),
    .rdata (mem_rdata)
  );

  // ===========================================================
  // outputs
  assign prdata      = s_reg.prdata;
  assign pready      = 1'b1;
  assign pslverr     = psel & penable & (sel == ULS_SEL_NONE);
  assign irq         = |(s_reg.isr & s_reg.imr);
  assign tx_wr_valid = s_reg.tx_wr_valid;
  assign tx_wr_data  = s_reg.tx_wr_data;
  assign tx_pending  = ~thre;

endmodule

// File: dv/uls_top_asserts.sv
`timescale 1ns/1ps
// ===========================================================
// port checks; reads see state captured at the setup edge
module uls_top_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        irq,
  input wire logic        rx_char_valid,
  input wire logic        tx_load,
  input wire logic        tx_shift_busy,
  input wire logic        tx_wr_valid,
  input wire logic [7:0]  tx_wr_data,
  input wire logic        tx_pending
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rx_seen;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) rx_seen <= 1'b0;
    else if (rx_char_valid) rx_seen <= 1'b1;
  sequence s_lsr_rd;
    psel && !penable && !pwrite && paddr == 8'h04;
  endsequence
  sequence s_dat_wr;
    psel && penable && pwrite && paddr == 8'h00;
  endsequence
  chk_wr_handoff: assert property (s_dat_wr |=> tx_wr_valid && tx_wr_data == $past(pwdata[7:0]))
    else $error("written byte not handed on");
  chk_pend_set: assert property (s_dat_wr |=> tx_pending)
    else $error("write left transmit queue empty");
  chk_pend_hold: assert property (tx_pending && !tx_load && !(psel && penable && pwrite) |=> tx_pending)
    else $error("transmit data vanished");
  chk_thre_read: assert property (s_lsr_rd |=> prdata[5] == !$past(tx_pending))
    else $error("holding empty wrong");
  chk_temt_read: assert property (s_lsr_rd |=> prdata[6] == !($past(tx_pending) || $past(tx_shift_busy)))
    else $error("transmitter empty wrong");
  chk_err_clean: assert property ((s_lsr_rd and !rx_seen) |=> prdata[7] == 1'b0 && prdata[4:2] == 3'h0)
    else $error("error flag without traffic");
  chk_ready_idle: assert property ((s_lsr_rd and !rx_seen) |=> prdata[1:0] == 2'h0)
    else $error("receive flag without traffic");
  chk_irq_quiet: assert property ($rose(presetn) |-> !irq ##1 !irq)
    else $error("interrupt after reset");
endmodule

bind uls_top uls_top_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .irq,
  .rx_char_valid, .tx_load, .tx_shift_busy, .tx_wr_valid, .tx_wr_data, .tx_pending);

// File: dv/uls_shift_model.sv
`timescale 1ns/1ps
// ===========================================================
// transmit shifter: takes a byte when pending, busy for a frame
module uls_shift_model #(
  parameter int BITS = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stall,
  input wire logic tx_pending,
  output logic     tx_load,
  output logic     tx_shift_busy
);
  int cnt;
  // stall lets the bench hold data in the queue
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      tx_load <= 1'b0;
    end else begin
      tx_load <= 1'b0;
      if (cnt > 0) cnt <= cnt - 1;
      else if (tx_pending && !stall && !tx_load) begin
        tx_load <= 1'b1;
        cnt <= BITS;
      end
    end
  end
  assign tx_shift_busy = cnt > 0;
endmodule

// File: dv/uls_top_tb.sv
`timescale 1ns/1ps
// ===========================================================
// bench: tasks queue expected reads, a monitor compares
module uls_top_tb;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stall = 1'b1;
  logic        rx_char_valid = 1'b0, rx_parity_err = 1'b0, rx_parity_bit = 1'b0, rx_stop_bit = 1'b1;
  logic        rx_line = 1'b1, pready, pslverr, irq, tx_load, tx_shift_busy, tx_wr_valid, tx_pending;
  logic [7:0]  paddr = 8'h00, rx_char_data = 8'h00, tx_wr_data, c1, c2;
  logic [31:0] pwdata = 32'h0, prdata, exp_v, msk_v, exp_q[$], msk_q[$];
  int          mismatches = 0, checks = 0;
  always #12.5 pclk = ~pclk;
  uls_top #(.DEPTH(4)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq, .rx_char_valid, .rx_char_data, .rx_parity_err, .rx_parity_bit, .rx_stop_bit, .rx_line,
    .tx_load, .tx_shift_busy, .tx_wr_valid, .tx_wr_data, .tx_pending);
  uls_shift_model u_shift (.pclk, .presetn, .stall, .tx_pending, .tx_load, .tx_shift_busy);
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && exp_q.size() > 0) begin
      exp_v = exp_q.pop_front();
      msk_v = msk_q.pop_front();
      cmp(prdata & msk_v, exp_v & msk_v);
    end
  end
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask
  task rx(input logic [7:0] d, input logic pe, input logic st);
    rx_char_valid <= 1'b1;
    rx_char_data <= d;
    rx_parity_err <= pe;
    rx_parity_bit <= pe;
    rx_stop_bit <= st;
    @(posedge pclk);
    rx_char_valid <= 1'b0;
    @(posedge pclk);
  endtask
  // bounded wait, busy optional
  task settle(input logic b);
    repeat (200) if (tx_pending === 1'b1 || (b && tx_shift_busy === 1'b1)) @(posedge pclk);
  endtask
  task end_of_test;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    end_of_test;
  end
  initial begin
    void'($urandom(32'h172CBA1D));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h04, 32'h60);
    rd(8'h10, 32'h0);
    rd(8'h40, 32'h0);
    $display("test reset done");
    c1 = 8'($urandom) | 8'h01;
    c2 = c1 ^ 8'hF0;
    apb(1'b1, 8'h00, {24'h0, c1});
    cmp({24'h0, tx_wr_data}, {24'h0, c1});
    rd(8'h04, 32'h00);
    stall <= 1'b0;
    settle(1'b0);
    rd(8'h04, 32'h20);
    settle(1'b1);
    rd(8'h04, 32'h60);
    rd(8'h0C, 32'h4);
    apb(1'b1, 8'h10, 32'h4);
    cmp({31'h0, irq}, 32'h1);
    apb(1'b1, 8'h0C, 32'h4);
    cmp({31'h0, irq}, 32'h0);
    $display("test char transmit done");
    rx(c1, 1'b0, 1'b1);
    rx(c2, 1'b0, 1'b1);
    rd(8'h04, 32'h63);
    rd(8'h04, 32'h61);
    rd(8'h00, {24'h0, c1});
    rd(8'h04, 32'h60);
    $display("test char receive done");
    apb(1'b1, 8'h08, 32'h1);
    stall <= 1'b1;
    repeat (3) apb(1'b1, 8'h00, $urandom);
    rd(8'h04, 32'h00);
    stall <= 1'b0;
    settle(1'b1);
    rd(8'h04, 32'h60);
    $display("test fifo transmit done");
    rx(c1, 1'b0, 1'b1);
    rx(c2, 1'b0, 1'b0);
    rx(c1, 1'b1, 1'b1);
    rd(8'h04, 32'hE1);
    rd(8'h00, {24'h0, c1});
    rd(8'h04, 32'hE9);
    rd(8'h00, {24'h0, c2});
    rd(8'h04, 32'hE5);
    rd(8'h00, {24'h0, c1});
    rd(8'h04, 32'h60);
    rx_line <= 1'b0;
    rx(8'h00, 1'b0, 1'b0);
    rx(8'h00, 1'b0, 1'b0);
    rx_line <= 1'b1;
    rd(8'h04, 32'hF1, 32'hF7);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h60);
    $display("test fifo receive done");
    end_of_test;
  end
endmodule
